// file: hw/cst_pkg.sv
// Package of constants and functions for the cyclic sense timer block.
`default_nettype none
package cst_pkg;
  // Printed offsets are not all multiples of four: these are word indices.
  localparam logic [7:0] TMR1_IDX   = 8'h0c;
  localparam logic [7:0] TMR2_IDX   = 8'h0d;
  localparam logic [7:0] FLT_IDX    = 8'h09;
  localparam logic [7:0] WKEN_IDX   = 8'h0e;
  localparam logic [7:0] SYS_IDX    = 8'h0f;
  localparam logic [7:0] STAT_IDX   = 8'h10;
  localparam int         IDX_LSB    = 2;
  localparam logic [7:0] TMR_MASK   = 8'h77;
  localparam logic [7:0] FLT_MASK   = 8'h3f;
  localparam logic [7:0] WKEN_MASK  = 8'hc0;
  localparam logic [7:0] RST_VAL    = 8'h00;
  localparam int ON_LSB  = 4;
  localparam int PER_LSB = 0;
  localparam int WKEN1_BIT = 6;
  localparam int WKEN2_BIT = 7;
  localparam int CLK_MHZ = 40;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int FLT_SHORT_US = 16;
  localparam int FLT_LONG_US  = 64;
  localparam int FLT_SHORT_CYC = FLT_SHORT_US * CLK_MHZ;
  localparam int FLT_LONG_CYC  = FLT_LONG_US * CLK_MHZ;
  localparam logic [2:0] ON_LOW  = 3'h0;
  localparam logic [2:0] ON_HIGH = 3'h6;
  localparam logic [2:0] CODE_RSV = 3'h7;
  localparam logic [1:0] FLT_S16 = 2'h0;
  localparam logic [1:0] FLT_S64 = 2'h1;
  localparam logic [1:0] FLT_C1  = 2'h2;
  localparam logic [1:0] FLT_C2  = 2'h3;
  // Durations in 100 us ticks.
  function automatic logic [15:0] cst_on_ticks(input logic [2:0] c);
    case (c)
      3'h1:    cst_on_ticks = 16'h0001;
      3'h2:    cst_on_ticks = 16'h0003;
      3'h3:    cst_on_ticks = 16'h000a;
      3'h4:    cst_on_ticks = 16'h0064;
      3'h5:    cst_on_ticks = 16'h00c8;
      default: cst_on_ticks = 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] cst_per_ticks(input logic [2:0] c);
    case (c)
      3'h0:    cst_per_ticks = 16'h0064;
      3'h1:    cst_per_ticks = 16'h00c8;
      3'h2:    cst_per_ticks = 16'h01f4;
      3'h3:    cst_per_ticks = 16'h03e8;
      3'h4:    cst_per_ticks = 16'h07d0;
      3'h5:    cst_per_ticks = 16'h2710;
      3'h6:    cst_per_ticks = 16'h4e20;
      default: cst_per_ticks = 16'h0000;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: hw/cst_timer.sv
// One cyclic timer: period and on-time counted in 100 us ticks.
`default_nettype none
module cst_timer
  import cst_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_on_code,
  input  wire logic [2:0] i_per_code,
  input  wire logic       i_assigned,
  output logic            o_out,
  output logic            o_on_end
);
  logic [15:0] cnt;
  logic        run;
  wire  [15:0] on_t  = cst_on_ticks(i_on_code);
  wire  [15:0] per_t = cst_per_ticks(i_per_code);
  wire rsv  = (i_on_code == CODE_RSV) || (i_per_code == CODE_RSV);
  wire live = i_assigned && !rsv && (on_t != 16'h0000);
  wire wrap = (cnt + 16'h0001 >= per_t);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 16'h0000;
      run <= 1'b0;
      o_out <= 1'b0;
      o_on_end <= 1'b0;
    end else begin
      o_on_end <= 1'b0;
      run <= live;
      if (!live) begin
        cnt <= 16'h0000;
        o_out <= (!rsv && i_on_code == ON_HIGH && i_assigned); // RQ9 RQ20
      end else if (!run) begin
        cnt <= 16'h0000;
        o_out <= 1'b1; // RQ14
      end else if (i_tick) begin
        cnt <= wrap ? 16'h0000 : cnt + 16'h0001; // RQ19
        o_out <= wrap || (cnt + 16'h0001 < on_t);
        o_on_end <= (cnt + 16'h0001 == on_t);
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/cst_top.sv
// Cyclic sense timers and wake input filters with an APB register port.
// Notes on behaviour
// RQ1: Filter code 00 accepts a wake level after 16 us stable.
// RQ2: Filter code 01 accepts a wake level after 64 us stable.
// RQ3: Code 10 samples with 16 us filter at end of timer one on-time.
// RQ4: Code 11 samples with 16 us filter at end of timer two on-time.
// RQ5: Filter register holds input c at 5:4, b at 3:2, a at 1:0.
// RQ6: Reserved bits of filter and timer registers read zero.
// RQ7: Software assigns the sensing timer to a switch during cyclic sense.
// RQ8: On-time codes 001..101 give 0.1, 0.3, 1, 10, 20 ms.
// RQ9: On code 000 stops timer output low; 110 stops it high.
// RQ10: Period codes 000..110 give 10 ms up to 2 s.
// RQ11: Second timer on-time uses the same encoding.
// RQ12: Second timer period uses the same encoding.
// RQ13: On-time at 6:4, period at 2:0; hardware may also alter them.
// RQ14: Timer runs once assigned and a running on-time is written.
// RQ15: Switch clear in restart with cyclic sense clears the timer fields.
// RQ16: Wake-enabled timer gives cyclic wake alongside cyclic sensing.
// RQ17: Timer registers reset to zero and read zero after restart.
// RQ18: Wake enable bit 7 for timer two, bit 6 for timer one.
// RQ19: Running timer repeats each period, active on-time at its start.
// RQ20: Reserved period or on-time code leaves timer stopped, output low.
//
// The APB interface to the registers was chosen for this implementation.
`default_nettype none
module cst_top
  import cst_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  i_wake_in,
  input  wire logic        i_restart,
  input  wire logic        i_hs_clear,
  output logic      [1:0]  o_high_side_switch_output,
  output logic      [2:0]  o_wake_level,
  output logic      [2:0]  o_wake_event,
  output logic      [1:0]  o_timer_wake
);
  logic       rst_m, rst_s;
  logic [7:0] tmr1, tmr2, flt, wken, sys;
  logic [15:0] tick_cnt [2];
  logic [1:0] tick;
  logic [1:0] tout, tend;
  logic [1:0] tend_d;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // APB decode; two-cycle transfers with no wait states.
  wire [7:0] idx   = paddr[IDX_LSB+7:IDX_LSB];
  wire       hit_t1 = (idx == TMR1_IDX);
  wire       hit_t2 = (idx == TMR2_IDX);
  wire       hit_fl = (idx == FLT_IDX);
  wire       hit_we = (idx == WKEN_IDX);
  wire       hit_sy = (idx == SYS_IDX);
  wire       hit_st = (idx == STAT_IDX);
  wire       mapped = hit_t1 | hit_t2 | hit_fl | hit_we | hit_sy | hit_st;
  wire       acc    = psel && penable && pready;
  wire       wr     = acc && pwrite && mapped && (paddr[1:0] == 2'h0);
  wire [7:0] wd     = pwdata[7:0];
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_t1)      rd_mux = tmr1 & TMR_MASK; // RQ6
    else if (hit_t2) rd_mux = tmr2 & TMR_MASK;
    else if (hit_fl) rd_mux = flt & FLT_MASK;
    else if (hit_we) rd_mux = wken & WKEN_MASK;
    else if (hit_sy) rd_mux = sys;
    else if (hit_st) rd_mux = {1'b0, o_wake_level, 2'h0, tout};
    else             rd_mux = 8'h00;
  end

  // Cyclic sense with switch clear in restart clears the timer fields.
  wire cyc1 = (flt[1:0] == FLT_C1) || (flt[3:2] == FLT_C1) ||
              (flt[5:4] == FLT_C1);
  wire cyc2 = (flt[1:0] == FLT_C2) || (flt[3:2] == FLT_C2) ||
              (flt[5:4] == FLT_C2);
  wire hw_clr1 = i_restart && i_hs_clear && cyc1; // RQ15
  wire hw_clr2 = i_restart && i_hs_clear && cyc2; // RQ15

  always_ff @(posedge i_sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      tmr1 <= RST_VAL; // RQ17
      tmr2 <= RST_VAL;
      flt  <= RST_VAL;
      wken <= RST_VAL;
      sys  <= RST_VAL;
    end else begin
      if (hw_clr1) tmr1 <= RST_VAL; // RQ13 RQ17
      else if (wr && hit_t1) tmr1 <= wd & TMR_MASK;
      if (hw_clr2) tmr2 <= RST_VAL;
      else if (wr && hit_t2) tmr2 <= wd & TMR_MASK;
      if (wr && hit_fl) flt <= wd & FLT_MASK; // RQ5
      if (wr && hit_we) wken <= wd & WKEN_MASK; // RQ18
      if (wr && hit_sy) sys <= wd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_mux}
                                              : prdata;
    end
  end

  // A timer runs only when it is assigned and both of its codes are
  // running ones; every other combination stops it.
  function automatic logic tmr_live(input logic [7:0] r, input logic a);
    tmr_live = a && (cst_on_ticks(r[ON_LSB+2:ON_LSB]) != 16'h0000) &&
               (r[PER_LSB+2:PER_LSB] != CODE_RSV);
  endfunction
  wire [1:0] t_live = {tmr_live(tmr2, sys[1]), tmr_live(tmr1, sys[0])};

  // 100 us time base, one divider per timer, held at zero while its timer
  // is stopped. A shared free-running divider would cut the first on-time
  // after a start short by up to one tick.
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_tick
      wire tick_wrap = (tick_cnt[d] == 16'(TICK_CYC - 1));
      always_ff @(posedge i_sys_clk or negedge rst_s) begin
        if (!rst_s) begin
          tick_cnt[d] <= 16'h0000;
          tick[d]     <= 1'b0;
        end else if (!t_live[d]) begin
          tick_cnt[d] <= 16'h0000;
          tick[d]     <= 1'b0;
        end else begin
          tick_cnt[d] <= tick_wrap ? 16'h0000 : tick_cnt[d] + 16'h0001;
          tick[d]     <= tick_wrap;
        end
      end
    end
  endgenerate

  // Timer assignment to a switch: bit 0 for timer one, bit 1 for timer two.
  cst_timer u_t1 (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (rst_s),
    .i_tick     (tick[0]),
    .i_on_code  (tmr1[ON_LSB+2:ON_LSB]), // RQ8 RQ13
    .i_per_code (tmr1[PER_LSB+2:PER_LSB]), // RQ10
    .i_assigned (sys[0]), // RQ14
    .o_out      (tout[0]),
    .o_on_end   (tend[0])
  );
  cst_timer u_t2 (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (rst_s),
    .i_tick     (tick[1]),
    .i_on_code  (tmr2[ON_LSB+2:ON_LSB]), // RQ11
    .i_per_code (tmr2[PER_LSB+2:PER_LSB]), // RQ12
    .i_assigned (sys[1]),
    .o_out      (tout[1]),
    .o_on_end   (tend[1])
  );

  always_ff @(posedge i_sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      o_high_side_switch_output <= 2'h0;
      o_timer_wake <= 2'h0;
      tend_d <= 2'h0;
    end else begin
      o_high_side_switch_output <= tout;
      tend_d <= tend;
      // Cyclic wake needs its timer assigned to a switch; the filter codes do not gate it.
      o_timer_wake <= tend & {wken[WKEN2_BIT], wken[WKEN1_BIT]}; // RQ16 RQ18
    end
  end

  // Wake filters, one per input.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flt
      logic [11:0] fc;
      logic        lvl;
      logic        win;
      wire [1:0]   mode = flt[2*g+1:2*g];
      wire         cyc  = mode[1];
      // A cyclic window opens when the timer output goes high, restarts on any input
      // change and is judged at the on-time end, so the input is valid while the switch is on.
      wire [11:0]  need = (mode == FLT_S64) ? 12'(FLT_LONG_CYC)
                                            : 12'(FLT_SHORT_CYC);
      wire         tact = (mode == FLT_C1) ? tout[0] : tout[1];
      wire         tfin = (mode == FLT_C1) ? tend[0] : tend[1];
      wire         same = (i_wake_in[g] == lvl);
      wire         full = (fc + 12'h001 >= need);
      always_ff @(posedge i_sys_clk or negedge rst_s) begin
        if (!rst_s) begin
          fc  <= 12'h000;
          lvl <= 1'b0;
          win <= 1'b0;
          o_wake_level[g] <= 1'b0;
          o_wake_event[g] <= 1'b0;
        end else begin
          o_wake_event[g] <= 1'b0;
          if (!cyc) begin
            if (same) fc <= 12'h000;
            else if (full) begin
              fc <= 12'h000;
              lvl <= i_wake_in[g]; // RQ1 RQ2
              o_wake_level[g] <= i_wake_in[g];
              o_wake_event[g] <= 1'b1;
            end else fc <= fc + 12'h001;
          end else begin
            if (!tact) begin
              fc <= 12'h000;
              win <= 1'b0;
            end else if (!win || i_wake_in[g] != lvl) begin
              fc <= 12'h000;
              win <= 1'b1;
              lvl <= i_wake_in[g];
            end else if (!full) fc <= fc + 12'h001;
            if (tfin && full && i_wake_in[g] == lvl) begin // RQ3 RQ4
              o_wake_level[g] <= lvl;
              o_wake_event[g] <= (lvl != o_wake_level[g]);
            end
          end
        end
      end
    end
  endgenerate

  wire [2:0] on1  = tmr1[ON_LSB+2:ON_LSB];
  wire [2:0] per1 = tmr1[PER_LSB+2:PER_LSB];

  // Stopped states are checked after three cycles so that the two
  // register stages between a write and the timer output have settled.
  chk_rsv_zero: assert property (@(posedge i_sys_clk) // RQ6
    disable iff (!rst_s)
    (tmr1[7] == 1'b0) && (tmr1[3] == 1'b0) && (flt[7:6] == 2'h0))
    else $error("reserved timer or filter bits set");

  chk_clr_timer: assert property (@(posedge i_sys_clk) // RQ15
    disable iff (!rst_s)
    hw_clr1 |=> (tmr1 == RST_VAL))
    else $error("timer one not cleared on restart switch clear");

  chk_clr_timer_two: assert property (@(posedge i_sys_clk) // RQ15
    disable iff (!rst_s)
    hw_clr2 |=> (tmr2 == RST_VAL))
    else $error("timer two not cleared on restart switch clear");

  chk_low_stop: assert property (@(posedge i_sys_clk) // RQ9
    disable iff (!rst_s)
    (on1 == ON_LOW) [*3] |-> (tout[0] == 1'b0))
    else $error("stopped low timer drives high");

  chk_high_stop: assert property (@(posedge i_sys_clk) // RQ9
    disable iff (!rst_s)
    (sys[0] && on1 == ON_HIGH && per1 != CODE_RSV) [*3] |-> tout[0])
    else $error("stopped high timer drives low");

  chk_rsv_low: assert property (@(posedge i_sys_clk) // RQ20
    disable iff (!rst_s)
    (on1 == CODE_RSV || per1 == CODE_RSV) [*3] |-> !tout[0])
    else $error("timer with reserved code drives high");

  chk_auto_start: assert property (@(posedge i_sys_clk) // RQ14
    disable iff (!rst_s)
    $rose(t_live[0]) |=> tout[0])
    else $error("assigned timer one did not start");

  chk_auto_start_two: assert property (@(posedge i_sys_clk) // RQ14
    disable iff (!rst_s)
    $rose(t_live[1]) |=> tout[1])
    else $error("assigned timer two did not start");

  chk_wake_gate: assert property (@(posedge i_sys_clk) // RQ18
    disable iff (!rst_s)
    o_timer_wake[0] |-> $past(wken[WKEN1_BIT]) && tend_d[0])
    else $error("timer wake without enable");

  chk_wake_gate_two: assert property (@(posedge i_sys_clk) // RQ18
    disable iff (!rst_s)
    o_timer_wake[1] |-> $past(wken[WKEN2_BIT]) && tend_d[1])
    else $error("timer two wake without enable");

  chk_sense_end: assert property (@(posedge i_sys_clk) // RQ3
    disable iff (!rst_s)
    $changed(o_wake_level[0]) && ($past(flt[1:0]) == FLT_C1)
    |-> $past(tend[0]))
    else $error("cyclic sample of input a away from on-time end");

  chk_sense_end_two: assert property (@(posedge i_sys_clk) // RQ4
    disable iff (!rst_s)
    $changed(o_wake_level[1]) && ($past(flt[3:2]) == FLT_C2)
    |-> $past(tend[1]))
    else $error("cyclic sample of input b away from on-time end");
endmodule
`default_nettype wire

// file: dv/test_cst_top.sv
// Self-checking bench for the cyclic sense timer and wake filter block.
`default_nettype none
module test_cst_top
  import cst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_sys_clk;
  logic        i_rst_b    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  i_wake_in  = 3'h0;
  logic        i_restart  = 1'b0;
  logic        i_hs_clear = 1'b0;
  logic [1:0]  hs;
  logic [2:0]  lvl;
  logic [2:0]  ev;
  logic [1:0]  twk;
  int          bad_count  = 0;
  int          checked    = 0;

  cst_top dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_wake_in(i_wake_in), .i_restart(i_restart), .i_hs_clear(i_hs_clear),
    .o_high_side_switch_output(hs), .o_wake_level(lvl), .o_wake_event(ev),
    .o_timer_wake(twk));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // Holds the request until pready is seen high, then idles one cycle so
  // that the next transfer never reassigns psel in the same time step.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 8'h00, q, e);
    chk32(q, {24'h0, exp});
    chk1(e, err);
  endtask

  // A glitch shorter than the filter time must not pass; a level held
  // just beyond it must.
  task automatic stat_filt(input logic [1:0] code, input int n,
                           input logic v);
    int e = 0;
    wr(FLT_IDX, {2'h0, code, 4'h0});
    i_wake_in[2] <= v;
    cyc(n - 120);
    i_wake_in[2] <= ~v;
    cyc(n);
    chk1(lvl[2], ~v);
    i_wake_in[2] <= v;
    repeat (n + 10) begin
      cyc(1);
      if (ev[2] === 1'b1) e++;
    end
    chk1(lvl[2], v);
    chk32(e, 32'h1);
  endtask

  task automatic run_timer(input int t);
    int n = 0;
    int w = 0;
    wr(SYS_IDX, t ? 8'h02 : 8'h01);
    wr(WKEN_IDX, t ? 8'h80 : 8'h40);
    wr(FLT_IDX, t ? 8'h0c : 8'h02);
    i_wake_in[t] <= 1'b1;
    wr(t ? TMR2_IDX : TMR1_IDX, 8'h10);
    while (hs[t] !== 1'b1 && n < 4100) begin
      cyc(1);
      n++;
    end
    chk1(lvl[t], 1'b0);
    n = 0;
    while (hs[t] === 1'b1 && n < 8000) begin
      cyc(1);
      n++;
      if (twk[t] === 1'b1) w++;
    end
    repeat (4) begin
      cyc(1);
      if (twk[t] === 1'b1) w++;
    end
    chk1(n >= TICK_CYC - 2 && n <= TICK_CYC + 2, 1'b1);
    chk32(w, 32'h1);
    chk1(lvl[t], 1'b1);
  endtask

  task automatic hold(input logic v, input int n);
    int h = 0;
    repeat (n) begin
      cyc(1);
      if (hs[0] !== v) h++;
    end
    chk32(h, 32'h0);
  endtask

  initial begin
    cyc(80000);
    bad_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] cv [5];
    logic       hv [5];
    cv = '{8'h60, 8'h70, 8'h60, 8'h17, 8'h00};
    hv = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    cyc(20);
    i_rst_b <= 1'b1;
    cyc(4);
    rd(TMR1_IDX, RST_VAL, 1'b0);
    rd(TMR2_IDX, RST_VAL, 1'b0);
    rd(FLT_IDX, RST_VAL, 1'b0);
    rd(8'h00, 8'h00, 1'b1);
    wr(TMR2_IDX, 8'hff);
    rd(TMR2_IDX, 8'h77, 1'b0);
    wr(TMR2_IDX, 8'h00);
    wr(FLT_IDX, 8'hff);
    rd(FLT_IDX, 8'h3f, 1'b0);
    stat_filt(FLT_S16, FLT_SHORT_CYC, 1'b1);
    stat_filt(FLT_S64, FLT_LONG_CYC, 1'b0);
    run_timer(0);
    run_timer(1);
    wr(SYS_IDX, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(TMR1_IDX, cv[i]);
      cyc(3);
      hold(hv[i], 4100);
    end
    wr(FLT_IDX, 8'h32);
    wr(TMR1_IDX, 8'h15);
    wr(TMR2_IDX, 8'h15);
    i_restart <= 1'b1;
    i_hs_clear <= 1'b1;
    cyc(4);
    rd(TMR1_IDX, 8'h00, 1'b0);
    rd(TMR2_IDX, 8'h00, 1'b0);
    i_restart <= 1'b0;
    i_hs_clear <= 1'b0;
    cyc(2);
    give_verdict();
  end
endmodule
`default_nettype wire
